// ===== bssd_cfg.svh
// constants for the skip, stop and subtract decoder
`ifndef BSSD_CFG_SVH
`define BSSD_CFG_SVH
`define BSSD_SKIP3_OP 9'h115
`define BSSD_SUBM_OP 9'h034
`define BSSD_SUBWB_OP 9'h036
`define BSSD_SUBI_OP 8'h1E
`define BSSD_STOP_OP 16'h0060
`define BSSD_PC_RST 11'h000
`define BSSD_ACCUM_RST 4'h0
`endif

// ===== bssd_core.sv
// decoder and execute for bit-3 skip, stop and subtract forms
`timescale 1ns/1ps
`include "bssd_cfg.svh"
// How it works
// - skip-if-bit3 recognised by its 9-bit prefix, 7-bit address follows
// - addressed nibble bit 3 set: program counter advances by two
// - bit 3 clear: program counter advances by one, single cycle
// - stop recognised as one fixed 16-bit word
// - stop halts oscillator; wake port falling edge resumes at next word
// - memory-minus-accumulator recognised by 9-bit prefix plus address
// - memory minus accumulator into accumulator only, flags updated
// - register-minus-immediate recognised by 8-bit prefix, immediate, reg
// - register minus immediate into accumulator only, flags updated
// - write-back subtract recognised by 9-bit prefix plus address
// - write-back subtract writes accumulator and memory, flags updated
module bssd_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [3:0] mem_rdata,
  input wire logic [3:0] wr_rdata,
  input wire logic wake_input_port,
  output logic [6:0] mem_addr_q,
  output logic [3:0] mem_wdata_q,
  output logic mem_we_q,
  output logic [3:0] wr_sel_q,
  output logic [10:0] pc_q,
  output logic [3:0] accumulator_q,
  output logic carry_flag_q,
  output logic zero_flag_q,
  output logic osc_halt_q,
  output logic decoded_q
);
  bssd_pkg::bssd_op_t op;
  bssd_pkg::bssd_state_t state_q;
  logic [3:0] sub_a;
  logic [3:0] sub_b;
  logic [3:0] diff;
  logic carry;
  logic zero;
  logic wake_q;
  logic wake_fall;
  logic exec;

  //////////////////////////////////////////////////////////////////////////
  // decode
  always_comb begin
    op = bssd_pkg::BSSD_OP_NONE;
    if (instr[15:7] == `BSSD_SKIP3_OP) begin
      op = bssd_pkg::BSSD_OP_SKIP3;
    end else if (instr == `BSSD_STOP_OP) begin
      op = bssd_pkg::BSSD_OP_STOP;
    end else if (instr[15:7] == `BSSD_SUBM_OP) begin
      op = bssd_pkg::BSSD_OP_SUBM;
    end else if (instr[15:8] == `BSSD_SUBI_OP) begin
      op = bssd_pkg::BSSD_OP_SUBI;
    end else if (instr[15:7] == `BSSD_SUBWB_OP) begin
      op = bssd_pkg::BSSD_OP_SUBWB;
    end
  end

  // the register form subtracts the immediate, the others the accumulator
  assign sub_a = (op == bssd_pkg::BSSD_OP_SUBI) ? wr_rdata : mem_rdata;
  assign sub_b = (op == bssd_pkg::BSSD_OP_SUBI) ? instr[7:4] : accumulator_q;
  assign exec = instr_valid && (state_q == bssd_pkg::BSSD_RUN);
  assign wake_fall = wake_q && !wake_input_port;

  bssd_sub4 u_sub (
    .a(sub_a),
    .b(sub_b),
    .diff(diff),
    .carry(carry),
    .zero(zero)
  );

  // operand addresses are combinational to memory; registered copies out
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_addr_q <= 7'h00;
      wr_sel_q <= 4'h0;
      decoded_q <= 1'b0;
    end else begin
      mem_addr_q <= instr[6:0];
      wr_sel_q <= instr[3:0];
      decoded_q <= exec && (op != bssd_pkg::BSSD_OP_NONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // program counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pc_q <= `BSSD_PC_RST;
    end else if (exec) begin
      if (op == bssd_pkg::BSSD_OP_SKIP3 && mem_rdata[3]) begin
        pc_q <= pc_q + 11'h002;
      end else begin
        pc_q <= pc_q + 11'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // accumulator and flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accumulator_q <= `BSSD_ACCUM_RST;
      carry_flag_q <= 1'b0;
      zero_flag_q <= 1'b0;
    end else if (exec && (op == bssd_pkg::BSSD_OP_SUBM ||
                          op == bssd_pkg::BSSD_OP_SUBI ||
                          op == bssd_pkg::BSSD_OP_SUBWB)) begin
      accumulator_q <= diff;
      carry_flag_q <= carry;
      zero_flag_q <= zero;
    end
  end

  // write-back only for the write-back form
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_we_q <= 1'b0;
      mem_wdata_q <= 4'h0;
    end else begin
      mem_we_q <= exec && (op == bssd_pkg::BSSD_OP_SUBWB);
      mem_wdata_q <= diff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // stop and wake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_q <= 1'b1;
    end else begin
      wake_q <= wake_input_port;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= bssd_pkg::BSSD_RUN;
      osc_halt_q <= 1'b0;
    end else begin
      unique case (state_q)
        bssd_pkg::BSSD_RUN: begin
          if (exec && op == bssd_pkg::BSSD_OP_STOP) begin
            state_q <= bssd_pkg::BSSD_STOPPED;
            osc_halt_q <= 1'b1;
          end
        end
        bssd_pkg::BSSD_STOPPED: begin
          if (wake_fall) begin
            state_q <= bssd_pkg::BSSD_RUN;
            osc_halt_q <= 1'b0;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_skip_two;
    @(posedge clk_sys) disable iff (rst)
    exec && op == bssd_pkg::BSSD_OP_SKIP3 && mem_rdata[3]
      |=> pc_q == $past(pc_q) + 11'h002;
  endproperty
  a_skip_two: assert property (p_skip_two)
    else $error("skip did not add two");

  property p_skip_one;
    @(posedge clk_sys) disable iff (rst)
    exec && op == bssd_pkg::BSSD_OP_SKIP3 && !mem_rdata[3]
      |=> pc_q == $past(pc_q) + 11'h001;
  endproperty
  a_skip_one: assert property (p_skip_one)
    else $error("no-skip did not add one");

  property p_stop_halts;
    @(posedge clk_sys) disable iff (rst)
    exec && instr == `BSSD_STOP_OP |=> osc_halt_q;
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("stop did not halt");

  property p_halt_holds_pc;
    @(posedge clk_sys) disable iff (rst)
    osc_halt_q && !wake_fall |=> osc_halt_q && $stable(pc_q);
  endproperty
  a_halt_holds_pc: assert property (p_halt_holds_pc)
    else $error("halt left without wake edge");

  property p_wake;
    @(posedge clk_sys) disable iff (rst)
    osc_halt_q && wake_fall |=> !osc_halt_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake edge ignored");

  property p_subm;
    @(posedge clk_sys) disable iff (rst)
    exec && instr[15:7] == `BSSD_SUBM_OP
      |=> accumulator_q == $past(mem_rdata) - $past(accumulator_q)
          && !mem_we_q;
  endproperty
  a_subm: assert property (p_subm)
    else $error("memory subtract wrong");

  property p_subi;
    @(posedge clk_sys) disable iff (rst)
    exec && instr[15:8] == `BSSD_SUBI_OP
      |=> accumulator_q == $past(wr_rdata) - $past(instr[7:4]);
  endproperty
  a_subi: assert property (p_subi)
    else $error("immediate subtract wrong");

  property p_subwb;
    @(posedge clk_sys) disable iff (rst)
    exec && instr[15:7] == `BSSD_SUBWB_OP
      |=> mem_we_q && mem_addr_q == $past(instr[6:0])
          && mem_wdata_q == $past(mem_rdata) - $past(accumulator_q)
          && accumulator_q == mem_wdata_q;
  endproperty
  a_subwb: assert property (p_subwb)
    else $error("write-back subtract wrong");

  property p_zero;
    @(posedge clk_sys) disable iff (rst)
    exec && instr[15:7] == `BSSD_SUBM_OP
      |=> zero_flag_q == (accumulator_q == 4'h0)
          && carry_flag_q == ($past(mem_rdata) >= $past(accumulator_q));
  endproperty
  a_zero: assert property (p_zero)
    else $error("flags wrong");
endmodule

// ===== bssd_pkg.sv
// types for the skip, stop and subtract decoder
package bssd_pkg;
  typedef enum logic [2:0] {
    BSSD_OP_NONE,
    BSSD_OP_SKIP3,
    BSSD_OP_STOP,
    BSSD_OP_SUBM,
    BSSD_OP_SUBI,
    BSSD_OP_SUBWB
  } bssd_op_t;
  typedef enum logic {
    BSSD_RUN,
    BSSD_STOPPED
  } bssd_state_t;
endpackage

// ===== bssd_sub4.sv
// 4-bit subtractor with carry and zero flags
`timescale 1ns/1ps
module bssd_sub4 (
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  output logic [3:0] diff,
  output logic carry,
  output logic zero
);
  logic [4:0] full;
  // carry set when no borrow occurs, matching add/sub convention
  assign full = {1'b0, a} + {1'b0, ~b} + 5'h01;
  assign diff = full[3:0];
  assign carry = full[4];
  assign zero = (full[3:0] == 4'h0);
endmodule

// ===== test_bit_skip_stop_subtract_decode.sv
// self-checking bench for the skip, stop and subtract decoder
`timescale 1ns/1ps
module test_bit_skip_stop_subtract_decode;
  logic clk_sys, rst, instr_valid, wake_input_port;
  logic [15:0] instr, a, word;
  logic [3:0] mem_rdata, wr_rdata, mem_wdata_q, wr_sel_q, accumulator_q;
  logic [6:0] mem_addr_q;
  logic [10:0] pc_q;
  logic mem_we_q, carry_flag_q, zero_flag_q, osc_halt_q, decoded_q;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int m_pc, m_accu, m_carry, m_zero, m_halt, m_we, m_dec, m_wd, k, n;

  bssd_core dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr(instr),
    .mem_rdata(mem_rdata),
    .wr_rdata(wr_rdata),
    .wake_input_port(wake_input_port),
    .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q),
    .mem_we_q(mem_we_q),
    .wr_sel_q(wr_sel_q),
    .pc_q(pc_q),
    .accumulator_q(accumulator_q),
    .carry_flag_q(carry_flag_q),
    .zero_flag_q(zero_flag_q),
    .osc_halt_q(osc_halt_q),
    .decoded_q(decoded_q)
  );

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // model: minuend, subtrahend; carry means no borrow
  task do_sub(input int x, input int y);
    m_accu = (x - y) & 15;
    m_carry = (x >= y);
    m_zero = (m_accu == 0);
  endtask

  task step(input logic v, input logic [15:0] ins, input logic [3:0] mr,
            input logic [3:0] wr);
    instr_valid = v;
    instr = ins;
    mem_rdata = mr;
    wr_rdata = wr;
    m_we = 0;
    m_dec = 0;
    if (v && m_halt == 0) begin
      m_pc = (m_pc + 1) & 2047;
      m_dec = 1;
      if (ins[15:7] == 9'h115) m_pc = (m_pc + mr[3]) & 2047;
      else if (ins == 16'h0060) m_halt = 1;
      else if (ins[15:7] == 9'h034) do_sub(mr, m_accu);
      else if (ins[15:8] == 8'h1E) do_sub(wr, ins[7:4]);
      else if (ins[15:7] == 9'h036) begin
        do_sub(mr, m_accu);
        m_we = 1;
        m_wd = m_accu;
      end
      else m_dec = 0;
    end
    @(negedge clk_sys);
    chk(pc_q, 16'(m_pc));
    chk(accumulator_q, 16'(m_accu));
    chk(carry_flag_q, 16'(m_carry));
    chk(zero_flag_q, 16'(m_zero));
    chk(osc_halt_q, 16'(m_halt));
    chk(decoded_q, 16'(m_dec));
    chk(mem_we_q, 16'(m_we));
    chk(mem_addr_q, 16'(ins[6:0]));
    chk(wr_sel_q, 16'(ins[3:0]));
    if (m_we == 1) begin
      chk(mem_wdata_q, 16'(m_wd));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1;
    instr_valid = 0;
    instr = 16'h0000;
    mem_rdata = 4'h0;
    wr_rdata = 4'h0;
    wake_input_port = 0;
    m_pc = 0;
    m_accu = 0;
    m_carry = 0;
    m_zero = 0;
    m_halt = 0;
    k = $urandom(19);
    repeat (2) @(negedge clk_sys);
    rst = 0;
    step(0, 16'h0000, 4'h0, 4'h0);
    step(1, 16'h1E53, 4'h0, 4'h3);
    step(1, 16'h1A7F, 4'hF, 4'h0);
    step(1, 16'h1B05, 4'h0, 4'h0);
    step(1, 16'h1B06, 4'h0, 4'h0);
    step(1, 16'h8A80, 4'h8, 4'h0);
    step(1, 16'h8AFF, 4'h7, 4'h0);
    for (int i = 0; i < 400; i++) begin
      k = $urandom % 5;
      a = $urandom;
      case (k)
        0: word = {9'h115, a[6:0]};
        1: word = {9'h034, a[6:0]};
        2: word = {9'h036, a[6:0]};
        3: word = {8'h1E, a[7:0]};
        default: word = {9'h070, a[6:0]};
      endcase
      step(($urandom % 8) != 0, word, 4'($urandom), 4'($urandom));
    end
    for (int j = 0; j < 2; j++) begin
      step(1, 16'h0060, 4'h0, 4'h0);
      step(1, 16'h1A01, 4'h9, 4'h0);
      wake_input_port = 1;
      step(1, 16'h8A80, 4'hF, 4'h0);
      wake_input_port = 0;
      instr_valid = 0;
      n = 0;
      while (osc_halt_q !== 1'b0 && n < 4) begin
        @(negedge clk_sys);
        n++;
      end
      m_halt = 0;
      chk(osc_halt_q, 16'h0000);
      step(1, 16'h1A22, 4'h5, 4'h0);
    end
    finish_test();
  end
endmodule
